// [hdl/mtor_bank.sv]
// Modem timing and option setting registers with the timers that they steer.
//
// Notes on behaviour
// - After carrier loss wait hang-up delay times 100 ms, then hang up.
// - A tone burst lasts tone length times 10 ms; only 5 to 25 accepted.
// - The gap between tones equals the tone length.
// - Escape needs guard times 50 ms of silence before and after it.
// - Option bit 0 enables half-duplex line turnaround.
// - Option bit 1 enables echo of command characters.
// - Option bit 2 set suppresses result codes.
// - Option bit 3 selects word (1) or numeric (0) result codes.
// - Option bit 4 selects hexadecimal (1) or decimal (0) value output.
// - Option bit 5 enables the fast connect procedure.
// - Option bit 6 enables the hardware escape pin.
// - Option bit 7 is originate (1) or answer (0), set by last command.
// - Ending remote loopback turns carrier off for carrier-off times 10 ms.
// - Local loopback drops after carrier absent longer than drop time times 10 ms.
// - Answer handshake aborts after handshake timeout seconds.
// - A diagnostic test stops after test timer seconds, back to command mode.
// - A test timer of zero disables the test timeout.
// - The test-stop command ends a test and returns to data mode.
// - The escape sequence is three escape characters, default code 43.
module mtor_bank import mtor_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic cfg_wr, // Register write strobe
  input wire logic cfg_rd, // Register read strobe
  input wire logic [7:0] cfg_addr, // Setting register number
  input wire logic [7:0] cfg_wdata, // Write data
  output logic [7:0] cfg_rdata_r, // Read data, held until next read
  output logic cfg_ack_r, // Access done pulse
  output logic cfg_err_r, // Access refused pulse
  input wire mtor_cmd_t cmd, // Decoded command pulses
  input wire logic [7:0] escape_char, // Programmed escape character
  output mtor_opts_t opts_r, // General options register
  input wire logic carrier_det, // Received carrier pin, async
  input wire logic escape_pin, // Hardware escape pin, async, active high
  input wire logic online, // Call in progress
  output logic hangup_r, // Go on-hook pulse
  input wire logic dial_valid, // Tone digit request
  input wire logic [3:0] dial_digit, // Digit to send
  output logic dial_ready_r, // Tone dialler ready for a digit
  output logic tone_on_r, // Tone burst active
  output logic [3:0] tone_digit_r, // Digit being sent
  input wire logic data_mode, // Data transfer mode
  input wire logic host_char_valid, // Character from host
  input wire logic [7:0] host_char, // Character value
  output logic escape_r, // Escape to command mode pulse
  input wire logic remote_loop_end, // End remote loopback request pulse
  output logic carrier_off_r, // Transmit carrier suppressed
  input wire logic local_loop_req, // Remote modem asks for local loopback pulse
  output logic local_loop_r, // Local loopback active
  input wire logic hs_active, // Answer handshake in progress
  output logic hs_abort_r, // Handshake abort pulse
  input wire logic test_start, // Start diagnostic test pulse
  output logic test_run_r, // Diagnostic test running
  output logic test_timeout_r, // Test timed out, to command mode pulse
  output logic test_to_data_r // Test stopped, to data mode pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mtor_scale(input logic [7:0] v, input logic [7:0] m);
    mtor_scale = {8'h00, v} * {8'h00, m};
  endfunction

  function automatic logic [15:0] mtor_inc(input logic [15:0] v);
    mtor_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and time base
  // ----------------------------------------------------------------
  logic [1:0] carrier_sync_r;
  logic [1:0] escpin_sync_r;
  logic escpin_d_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_sync_r <= 2'b00;
      escpin_sync_r <= 2'b00;
      escpin_d_r <= 1'b0;
    end else begin
      carrier_sync_r <= {carrier_sync_r[0], carrier_det};
      escpin_sync_r <= {escpin_sync_r[0], escape_pin};
      escpin_d_r <= escpin_sync_r[1];
    end
  end

  wire carrier_s = carrier_sync_r[1];
  wire escpin_rise = escpin_sync_r[1] & ~escpin_d_r;
  wire tick_wrap = (tick_cnt_r == 32'(TICK_LEN - 1));

  // One enable pulse every 10 ms; every longer unit is a multiple of it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? 32'h0 : tick_cnt_r + 32'h1;
      tick_r <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  logic [7:0] hang_dly_r, tone_len_r, guard_r, coff_r, drop_r, hs_to_r, test_tmr_r;

  wire wr_tone_ok = (cfg_wdata >= TONE_LEN_MIN) && (cfg_wdata <= TONE_LEN_MAX);
  wire addr_hit = (cfg_addr >= REG_HANGUP_DELAY) && (cfg_addr <= REG_TEST_TIMER);
  wire wr_bad = cfg_wr && (!addr_hit || cfg_addr == REG_RESERVED_A ||
                           (cfg_addr == REG_TONE_LENGTH && !wr_tone_ok));
  wire wr_go = cfg_wr && !wr_bad;
  wire [7:0] rd_mux =
    (cfg_addr == REG_HANGUP_DELAY) ? hang_dly_r :
    (cfg_addr == REG_TONE_LENGTH) ? tone_len_r :
    (cfg_addr == REG_GUARD_TIME) ? guard_r :
    (cfg_addr == REG_GEN_OPTIONS) ? opts_r :
    (cfg_addr == REG_CARRIER_OFF) ? coff_r :
    (cfg_addr == REG_DROP_TIME) ? drop_r :
    (cfg_addr == REG_HS_TIMEOUT) ? hs_to_r :
    (cfg_addr == REG_TEST_TIMER) ? test_tmr_r : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hang_dly_r <= RST_HANGUP_DELAY;
      tone_len_r <= RST_TONE_LENGTH;
      guard_r <= RST_GUARD_TIME;
      coff_r <= RST_CARRIER_OFF;
      drop_r <= RST_DROP_TIME;
      hs_to_r <= RST_HS_TIMEOUT;
      test_tmr_r <= RST_TEST_TIMER;
    end else if (wr_go) begin
      if (cfg_addr == REG_HANGUP_DELAY) hang_dly_r <= cfg_wdata;
      if (cfg_addr == REG_TONE_LENGTH) tone_len_r <= cfg_wdata;
      if (cfg_addr == REG_GUARD_TIME) guard_r <= cfg_wdata;
      if (cfg_addr == REG_CARRIER_OFF) coff_r <= cfg_wdata;
      if (cfg_addr == REG_DROP_TIME) drop_r <= cfg_wdata;
      if (cfg_addr == REG_HS_TIMEOUT) hs_to_r <= cfg_wdata;
      if (cfg_addr == REG_TEST_TIMER) test_tmr_r <= cfg_wdata;
    end
  end

  // Command pulses land after a host write so the last command always shows.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opts_r <= mtor_opts_t'(RST_GEN_OPTIONS);
    end else begin
      if (wr_go && cfg_addr == REG_GEN_OPTIONS) opts_r <= mtor_opts_t'(cfg_wdata);
      if (cmd.echo_on_command) opts_r.echo_en <= 1'b1;
      if (cmd.echo_off_command) opts_r.echo_en <= 1'b0;
      if (cmd.results_on_command) opts_r.results_off <= 1'b0;
      if (cmd.results_off_command) opts_r.results_off <= 1'b1;
      if (cmd.numeric_results_command) opts_r.word_results <= 1'b0;
      if (cmd.word_results_command) opts_r.word_results <= 1'b1;
      if (cmd.answer_command) opts_r.originate <= 1'b0;
      if (cmd.dial_command) opts_r.originate <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata_r <= 8'h00;
      cfg_ack_r <= 1'b0;
      cfg_err_r <= 1'b0;
    end else begin
      cfg_ack_r <= cfg_wr | cfg_rd;
      cfg_err_r <= wr_bad | (cfg_rd & ~addr_hit);
      if (cfg_rd) cfg_rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Lost carrier hang-up
  // ----------------------------------------------------------------
  logic [15:0] hang_cnt_r;
  logic hang_done_r;
  wire hang_cnting = online && !carrier_s && !hang_done_r;
  wire hang_fire = hang_cnting && (hang_cnt_r > mtor_scale(hang_dly_r, MUL_100MS));

  // A count above the delay means strictly more than the delay has passed.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hang_cnt_r <= 16'h0;
      hang_done_r <= 1'b0;
      hangup_r <= 1'b0;
    end else begin
      hangup_r <= hang_fire;
      if (!online || carrier_s) begin
        hang_cnt_r <= 16'h0;
        hang_done_r <= 1'b0;
      end else begin
        if (tick_r) hang_cnt_r <= mtor_inc(hang_cnt_r);
        if (hang_fire) hang_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tone dialler
  // ----------------------------------------------------------------
  mtor_dt_state_t dt_state_r, dt_state_nxt;
  logic [15:0] dt_cnt_r;
  wire dt_last = tick_r && (dt_cnt_r + 16'h1 == {8'h00, tone_len_r});

  always_comb begin
    dt_state_nxt = dt_state_r;
    case (dt_state_r)
      DT_IDLE: if (dial_valid && dial_ready_r) dt_state_nxt = DT_SYNC;
      DT_SYNC: if (tick_r) dt_state_nxt = DT_TONE;
      DT_TONE: if (dt_last) dt_state_nxt = DT_GAP;
      DT_GAP: if (dt_last) dt_state_nxt = DT_IDLE;
      default: dt_state_nxt = DT_IDLE;
    endcase
  end

  // Bursts start on a tick edge so each lasts a whole number of 10 ms units.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dt_state_r <= DT_IDLE;
      dt_cnt_r <= 16'h0;
      dial_ready_r <= 1'b0;
      tone_on_r <= 1'b0;
      tone_digit_r <= 4'h0;
    end else begin
      dt_state_r <= dt_state_nxt;
      dial_ready_r <= (dt_state_nxt == DT_IDLE);
      tone_on_r <= (dt_state_nxt == DT_TONE);
      if (dt_state_r == DT_IDLE && dial_valid && dial_ready_r) tone_digit_r <= dial_digit;
      if (dt_state_nxt != dt_state_r) dt_cnt_r <= 16'h0;
      else if (tick_r) dt_cnt_r <= dt_cnt_r + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Escape detection
  // ----------------------------------------------------------------
  logic [15:0] quiet_cnt_r;
  logic [1:0] plus_cnt_r;
  wire [15:0] guard_ticks = mtor_scale(guard_r, MUL_50MS);
  wire quiet_ok = (quiet_cnt_r >= guard_ticks);
  wire is_esc = host_char_valid && (host_char == escape_char);
  wire seq_done = data_mode && (plus_cnt_r == 2'd3) && quiet_ok && !host_char_valid;
  wire pin_esc = opts_r.escape_pin_en && escpin_rise;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quiet_cnt_r <= 16'h0;
      plus_cnt_r <= 2'd0;
      escape_r <= 1'b0;
    end else begin
      escape_r <= seq_done | (pin_esc & data_mode);
      if (host_char_valid) quiet_cnt_r <= 16'h0;
      else if (tick_r) quiet_cnt_r <= mtor_inc(quiet_cnt_r);
      if (!data_mode || seq_done) plus_cnt_r <= 2'd0;
      else if (host_char_valid) begin
        if (is_esc && plus_cnt_r == 2'd0 && quiet_ok) plus_cnt_r <= 2'd1;
        else if (is_esc && (plus_cnt_r == 2'd1 || plus_cnt_r == 2'd2)) plus_cnt_r <= plus_cnt_r + 2'd1;
        else plus_cnt_r <= 2'd0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Remote loopback carrier off and local loopback drop
  // ----------------------------------------------------------------
  logic [15:0] coff_cnt_r, drop_cnt_r;
  wire coff_end = carrier_off_r && (coff_cnt_r > mtor_scale(coff_r, MUL_10MS));
  wire drop_end = local_loop_r && !carrier_s && (drop_cnt_r > mtor_scale(drop_r, MUL_10MS));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_off_r <= 1'b0;
      coff_cnt_r <= 16'h0;
      local_loop_r <= 1'b0;
      drop_cnt_r <= 16'h0;
    end else begin
      if (remote_loop_end) begin
        carrier_off_r <= 1'b1;
        coff_cnt_r <= 16'h0;
      end else if (coff_end) begin
        carrier_off_r <= 1'b0;
      end else if (carrier_off_r && tick_r) begin
        coff_cnt_r <= mtor_inc(coff_cnt_r);
      end
      if (local_loop_req) local_loop_r <= 1'b1;
      else if (drop_end) local_loop_r <= 1'b0;
      if (carrier_s || !local_loop_r) drop_cnt_r <= 16'h0;
      else if (tick_r) drop_cnt_r <= mtor_inc(drop_cnt_r);
    end
  end

  // ----------------------------------------------------------------
  // Handshake timeout and diagnostic test timer
  // ----------------------------------------------------------------
  logic [15:0] hs_cnt_r, test_cnt_r;
  logic hs_done_r;
  wire hs_fire = hs_active && !hs_done_r && (hs_cnt_r > mtor_scale(hs_to_r, MUL_1S));
  wire test_stop = test_run_r && cmd.test_stop_command;
  wire test_expire = test_run_r && (test_tmr_r != 8'h00) &&
                     (test_cnt_r > mtor_scale(test_tmr_r, MUL_1S));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hs_cnt_r <= 16'h0;
      hs_done_r <= 1'b0;
      hs_abort_r <= 1'b0;
    end else begin
      hs_abort_r <= hs_fire;
      if (!hs_active) begin
        hs_cnt_r <= 16'h0;
        hs_done_r <= 1'b0;
      end else begin
        if (tick_r) hs_cnt_r <= mtor_inc(hs_cnt_r);
        if (hs_fire) hs_done_r <= 1'b1;
      end
    end
  end

  // The stop command wins over a timeout that falls due in the same cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      test_run_r <= 1'b0;
      test_cnt_r <= 16'h0;
      test_timeout_r <= 1'b0;
      test_to_data_r <= 1'b0;
    end else begin
      test_to_data_r <= test_stop;
      test_timeout_r <= test_expire && !test_stop;
      if (test_stop || test_expire) test_run_r <= 1'b0;
      else if (test_start) begin
        test_run_r <= 1'b1;
        test_cnt_r <= 16'h0;
      end else if (test_run_r && tick_r) test_cnt_r <= mtor_inc(test_cnt_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_HANGUP_DELAY: assert property (hangup_r |->
    $past(hang_cnt_r) > mtor_scale($past(hang_dly_r), MUL_100MS) && $past(!carrier_s))
    else $error("hang-up issued before the delay ran out");
  AST_TONE_RANGE: assert property (tone_len_r >= TONE_LEN_MIN && tone_len_r <= TONE_LEN_MAX)
    else $error("tone length left its range");
  AST_TONE_LEN: assert property ($fell(tone_on_r) |-> $past(dt_cnt_r) + 16'h1 == {8'h00, $past(tone_len_r)})
    else $error("tone burst length wrong");
  AST_GAP_LEN: assert property ((dt_state_r == DT_IDLE && $past(dt_state_r) == DT_GAP) |->
    $past(dt_cnt_r) + 16'h1 == {8'h00, $past(tone_len_r)})
    else $error("tone gap length wrong");
  AST_ESC_GUARD: assert property ((escape_r && !$past(pin_esc)) |->
    $past(quiet_cnt_r) >= $past(guard_ticks) && $past(plus_cnt_r) == 2'd3)
    else $error("escape without guard time");
  AST_ECHO: assert property (cmd.echo_off_command && !cmd.echo_on_command |=> !opts_r.echo_en)
    else $error("echo not switched off");
  AST_DIRECTION: assert property (cmd.dial_command && !cmd.answer_command |=> opts_r.originate)
    else $error("dial did not set originate");
  AST_CARRIER_OFF: assert property ($fell(carrier_off_r) |->
    $past(coff_cnt_r) > mtor_scale($past(coff_r), MUL_10MS))
    else $error("carrier restored early");
  AST_LOOP_DROP: assert property (($fell(local_loop_r)) |-> $past(drop_cnt_r) > mtor_scale($past(drop_r), MUL_10MS))
    else $error("local loop dropped early");
  AST_HS_ABORT: assert property (hs_abort_r |-> $past(hs_cnt_r) > mtor_scale($past(hs_to_r), MUL_1S))
    else $error("handshake aborted early");
  AST_TEST_ZERO: assert property ((test_run_r && test_tmr_r == 8'h00) |=> !test_timeout_r)
    else $error("test timed out with timer off");
  AST_TEST_STOP: assert property ((test_run_r && cmd.test_stop_command) |=> !test_run_r && test_to_data_r)
    else $error("test stop not honoured");

endmodule

// [hdl/mtor_pkg.sv]
// Package with the constants, types and register numbers of the modem timing option bank.
package mtor_pkg;

  // ----------------------------------------------------------------
  // Register numbers (setting register index on the command port)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_HANGUP_DELAY = 8'h0a;
  localparam logic [7:0] REG_TONE_LENGTH = 8'h0b;
  localparam logic [7:0] REG_GUARD_TIME = 8'h0c;
  localparam logic [7:0] REG_RESERVED_A = 8'h0d;
  localparam logic [7:0] REG_GEN_OPTIONS = 8'h0e;
  localparam logic [7:0] REG_CARRIER_OFF = 8'h0f;
  localparam logic [7:0] REG_DROP_TIME = 8'h10;
  localparam logic [7:0] REG_HS_TIMEOUT = 8'h11;
  localparam logic [7:0] REG_TEST_TIMER = 8'h12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_HANGUP_DELAY = 8'h07;
  localparam logic [7:0] RST_TONE_LENGTH = 8'h0a;
  localparam logic [7:0] RST_GUARD_TIME = 8'h14;
  localparam logic [7:0] RST_GEN_OPTIONS = 8'h92;
  localparam logic [7:0] RST_CARRIER_OFF = 8'h08;
  localparam logic [7:0] RST_DROP_TIME = 8'h06;
  localparam logic [7:0] RST_HS_TIMEOUT = 8'h1e;
  localparam logic [7:0] RST_TEST_TIMER = 8'h00;
  localparam logic [7:0] RST_ESCAPE_CHAR = 8'h2b;

  // ----------------------------------------------------------------
  // Limits of the tone length register
  // ----------------------------------------------------------------
  localparam logic [7:0] TONE_LEN_MIN = 8'h05;
  localparam logic [7:0] TONE_LEN_MAX = 8'h19;

  // ----------------------------------------------------------------
  // Time base: all timers count 10 ms ticks
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BASE_UNIT_MS = 10;
  localparam int TICK_CYCLES = (BASE_UNIT_MS * 1000000 / CLK_PERIOD_PS) * 1000;
  localparam int UNIT_10MS_MS = 10;
  localparam int UNIT_50MS_MS = 50;
  localparam int UNIT_100MS_MS = 100;
  localparam int UNIT_1S_MS = 1000;
  localparam logic [7:0] MUL_10MS = 8'(UNIT_10MS_MS / BASE_UNIT_MS);
  localparam logic [7:0] MUL_50MS = 8'(UNIT_50MS_MS / BASE_UNIT_MS);
  localparam logic [7:0] MUL_100MS = 8'(UNIT_100MS_MS / BASE_UNIT_MS);
  localparam logic [7:0] MUL_1S = 8'(UNIT_1S_MS / BASE_UNIT_MS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic originate;
    logic escape_pin_en;
    logic fast_connect_en;
    logic hex_format;
    logic word_results;
    logic results_off;
    logic echo_en;
    logic turnaround_en;
  } mtor_opts_t;

  typedef struct packed {
    logic echo_on_command;
    logic echo_off_command;
    logic results_on_command;
    logic results_off_command;
    logic numeric_results_command;
    logic word_results_command;
    logic answer_command;
    logic dial_command;
    logic test_stop_command;
  } mtor_cmd_t;

  typedef enum logic [3:0] {
    DT_IDLE = 4'b0001,
    DT_SYNC = 4'b0010,
    DT_TONE = 4'b0100,
    DT_GAP = 4'b1000
  } mtor_dt_state_t;

endpackage

// [sim/mtor_bank_bench.sv]
// Self-checking bench of the modem timing option bank.
module mtor_bank_bench import mtor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, drop = 0, online = 0, dial_valid = 0, data_mode = 0;
  logic host_char_valid = 0, remote_loop_end = 0, local_loop_req = 0, hs_active = 0, test_start = 0, escpin = 0;
  logic [7:0] cfg_addr = 0, cfg_wdata = 0, host_char = 0, cfg_rdata_r, d;
  logic [3:0] dial_digit = 0, tone_digit_r;
  logic cfg_ack_r, cfg_err_r, carrier_det, hangup_r, dial_ready_r, tone_on_r, escape_r, carrier_off_r, ok, g_err;
  logic local_loop_r, hs_abort_r, test_run_r, test_timeout_r, test_to_data_r;
  mtor_cmd_t cmd = '0;
  mtor_opts_t opts_r;
  logic [7:0] rv [9] = '{8'h07, 8'h0a, 8'h14, 8'h00, 8'h92, 8'h08, 8'h06, 8'h1e, 8'h00};
  logic [7:0] cor [4] = '{8'h04, 8'h1a, 8'h05, 8'h19};
  int ob [8] = '{1, 1, 2, 2, 3, 3, 7, 7};
  logic lv [8] = '{1, 0, 0, 1, 0, 1, 0, 1};
  int n_mismatch = 0, cmp_count = 0, i, k;

  mtor_bank #(.TICK_LEN(10)) DUT (.ref_clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata_r,
    .cfg_ack_r, .cfg_err_r, .cmd, .escape_char(8'h2b), .opts_r, .carrier_det, .escape_pin(escpin), .online,
    .hangup_r, .dial_valid, .dial_digit, .dial_ready_r, .tone_on_r, .tone_digit_r, .data_mode, .host_char_valid,
    .host_char, .escape_r, .remote_loop_end, .carrier_off_r, .local_loop_req, .local_loop_r, .hs_active,
    .hs_abort_r, .test_start, .test_run_r, .test_timeout_r, .test_to_data_r);
  mtor_line LINE (.ref_clk, .drop, .carrier_det);

  initial forever #2 ref_clk = ~ref_clk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One register access; the error flag is a one-cycle pulse, so it is kept for the caller.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] dat);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_addr <= a;
    cfg_wdata <= dat;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    chk(cfg_ack_r, 1'b1);
    g_err = cfg_err_r;
    @(posedge ref_clk);
  endtask

  function automatic logic sel(input int s);
    case (s)
      0: return tone_on_r;
      1: return dial_ready_r;
      2: return hangup_r;
      3: return carrier_off_r;
      4: return hs_abort_r;
      5: return local_loop_r;
      6: return escape_r;
      default: return test_timeout_r;
    endcase
  endfunction

  // Counts edges while the chosen output holds lvl and checks the count lies in (lo, hi].
  task automatic win(input int s, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (sel(s) === lvl && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n > lo && n <= hi, 1'b1);
  endtask

  initial begin
    void'($urandom(60));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 9; i++) begin
      acc(1'b0, 8'h0a + 8'(i), 8'h00);
      chk({g_err, cfg_rdata_r}, {1'b0, rv[i]});
    end
    acc(1'b0, 8'h13, 8'h00);
    chk({g_err, cfg_rdata_r}, 9'h100);
    for (k = 0; k < 28; k++) begin
      i = (k < 4) ? 1 : $urandom_range(8, 0);
      d = (k < 4) ? cor[k] : ((i == 1) ? 8'(4 + $urandom_range(22, 0)) : 8'($urandom));
      ok = (i != 3) && (i != 1 || (d >= 8'h05 && d <= 8'h19));
      acc(1'b1, 8'h0a + 8'(i), d);
      chk(g_err, !ok);
      if (ok) rv[i] = d;
      acc(1'b0, 8'h0a + 8'(i), 8'h00);
      chk(cfg_rdata_r, rv[i]);
    end
    for (i = 0; i < 8; i++) begin
      cmd <= mtor_cmd_t'(9'h100 >> i);
      @(posedge ref_clk);
      cmd <= '0;
      #1;
      chk(opts_r[ob[i]], lv[i]);
    end
    acc(1'b1, 8'h0b, 8'h05);
    dial_digit <= 4'($urandom);
    dial_valid <= 1'b1;
    @(posedge ref_clk);
    dial_valid <= 1'b0;
    win(0, 1'b0, 0, 12);
    chk(tone_digit_r, dial_digit);
    win(0, 1'b1, 49, 50);
    win(1, 1'b0, 48, 52);
    acc(1'b1, 8'h0a, 8'h01);
    online <= 1'b1;
    repeat (4) @(posedge ref_clk);
    drop <= 1'b1;
    win(2, 1'b0, 100, 116);
    drop <= 1'b0;
    online <= 1'b0;
    acc(1'b1, 8'h0f, 8'h03);
    remote_loop_end <= 1'b1;
    @(posedge ref_clk);
    remote_loop_end <= 1'b0;
    win(3, 1'b1, 29, 42);
    acc(1'b1, 8'h10, 8'h02);
    local_loop_req <= 1'b1;
    @(posedge ref_clk);
    local_loop_req <= 1'b0;
    drop <= 1'b1;
    win(5, 1'b1, 20, 34);
    drop <= 1'b0;
    acc(1'b1, 8'h11, 8'h01);
    hs_active <= 1'b1;
    win(4, 1'b0, 1000, 1014);
    hs_active <= 1'b0;
    acc(1'b1, 8'h12, 8'h01);
    test_start <= 1'b1;
    @(posedge ref_clk);
    test_start <= 1'b0;
    win(7, 1'b0, 1000, 1014);
    acc(1'b1, 8'h12, 8'h00);
    test_start <= 1'b1;
    @(posedge ref_clk);
    test_start <= 1'b0;
    repeat (1100) @(posedge ref_clk);
    #1;
    chk(test_run_r, 1'b1);
    cmd.test_stop_command <= 1'b1;
    @(posedge ref_clk);
    cmd <= '0;
    #1;
    chk({test_run_r, test_to_data_r}, 2'b01);
    acc(1'b1, 8'h0c, 8'h01);
    data_mode <= 1'b1;
    host_char <= 8'h2b;
    host_char_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host_char_valid <= 1'b0;
    win(6, 1'b0, 40, 52);
    // The pin escape only acts once the option bit allows it.
    acc(1'b1, 8'h0e, 8'h40);
    escpin <= 1'b1;
    win(6, 1'b0, 1, 6);
    escpin <= 1'b0;
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

// [sim/mtor_line.sv]
// Far line model: the remote modem's carrier as seen at the receive pin.
module mtor_line (
  input wire logic ref_clk, // Bench clock
  input wire logic drop, // Remote modem stops its carrier
  output logic carrier_det // Carrier at the receive pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The carrier moves 1 ns after the edge so the synchroniser sees an unaligned change.
  always @(posedge ref_clk) carrier_det <= #1 !drop;
endmodule
